// file: logic/bfss_pkg.sv
// Shared constants, state codes and carrier types of the backlight fault state sequencer.
package bfss_pkg;

  localparam int CLK_KHZ        = 125000;
  localparam int SOFT_START_MS  = 25;
  localparam int CONV_RAMP_MS   = 50;
  localparam int RECOVERY_MS    = 100;
  localparam int DISCHARGE_MS   = 400;
  localparam int BUS_TIMEOUT_MS = 500;
  localparam int SHORT_DWELL_MS = 5;

  localparam int NCH  = 6;
  localparam int NFLT = 7;

  // Register word indices on the Avalon-MM slave.
  localparam logic [3:0] REG_BRIGHT  = 4'h0;
  localparam logic [3:0] REG_CURRENT = 4'h1;
  localparam logic [3:0] REG_STATUS  = 4'h2;
  localparam logic [3:0] REG_INT_EN  = 4'h3;
  localparam logic [3:0] REG_STATE   = 4'h4;
  localparam logic [3:0] REG_STRINGS = 4'h5;

  // Fault flag positions in the status register.
  localparam int FLT_CURRENT_SET_PIN    = 0;
  localparam int FLT_THERMAL = 1;
  localparam int FLT_OPEN    = 2;
  localparam int FLT_SHORT   = 3;
  localparam int FLT_GROUND  = 4;
  localparam int FLT_UNUSED  = 5;
  localparam int FLT_BUS     = 6;
  localparam int CLR_SHIFT   = 16;
  localparam int DIS_SHIFT   = 8;
  localparam int USED_SHIFT  = 16;

  localparam logic [1:0] IEN_WR_OFF = 2'h1;
  localparam logic [1:0] IEN_WR_ON  = 2'h3;
  localparam logic [1:0] IEN_RD_ON  = 2'h2;

  localparam logic [15:0]     BRIGHT_RST       = 16'hffff;
  localparam logic [11:0]     CURRENT_RST      = 12'hfff;
  localparam logic [11:0]     CURRENT_SET_PIN_FORCED_CODE = 12'h3ff;
  localparam logic [NFLT-1:0] INT_EN_RST       = 7'h7f;

  typedef enum logic [8:0] {
    ST_INIT     = 9'h001,
    ST_STANDBY  = 9'h002,
    ST_SOFT     = 9'h004,
    ST_RAMP     = 9'h008,
    ST_NORMAL   = 9'h010,
    ST_RECOVERY = 9'h020,
    ST_LATCH    = 9'h040,
    ST_SHUTDOWN = 9'h080,
    ST_OFF      = 9'h100
  } bfss_state_e;

  // Analog and pin indications, all asynchronous to the clock.
  typedef struct packed {
    logic           en;
    logic           overtemp;
    logic           current_set_pin_short;
    logic           init_done;
    logic           target_at_max;
    logic           bus_busy;
    logic [NCH-1:0] string_used;
    logic [NCH-1:0] headroom_low;
    logic [NCH-1:0] headroom_high;
    logic [NCH-1:0] ground_short;
    logic [NCH-1:0] unused_not_ground;
  } bfss_pins_s;

  // Power-path and fault-detector enables.
  typedef struct packed {
    logic init_start;
    logic pl_switch_en;
    logic conv_en;
    logic conv_ramp;
    logic discharge_en;
    logic supply_fault_en;
    logic conv_fault_en;
    logic led_fault_en;
  } bfss_pwr_s;

endpackage

// file: logic/bfss_sequencer.sv
// Operating state machine and fault response of the backlight driver.
//
// Functional notes
// - Current-set pin shorted low: flag, interrupt, no recovery, force current code 0x3ff.
// - Over-temperature: flag, interrupt, go to standby, restart only once it clears.
// - Used string low headroom at maximum converter target: flag, disable, drop from loop.
// - Headroom above short level over 5 ms while another is below: flag, disable.
// - In ramp or normal, used output low with channel off: ground short, recovery.
// - Recovery holds power off 100 ms, restarts via standby if enabled and brightness nonzero.
// - Unused output not grounded: flag and interrupt, keep operating, no recovery.
// - Bus transaction without stop for 500 ms: flag, interrupt, reset bus logic.
// - Enable low: converter, switch and drivers off, discharge 400 ms, then off.
// - After reset release: start regulator, load defaults, capture resistor detections.
// - Configuration writes are accepted from standby onward.
// - Standby moves at once to soft start when no fault is present.
// - Soft start lasts 25 ms; supply and ground-short faults enabled there.
// - Converter ramp lasts 50 ms with reduced limit; converter faults enabled from here.
// - Normal mode: drivers on only with nonzero brightness, all string faults active.
// - All strings disabled: latched fault state, left only by enable going low.
// - Interrupt enable fields: write 01 off, 11 on, read 10 when on.
//
// Register access over Avalon-MM and the register offsets were decided locally.
module bfss_sequencer
  import bfss_pkg::*;
#(
  parameter int SOFT_START_CYC  = SOFT_START_MS * CLK_KHZ,
  parameter int CONV_RAMP_CYC   = CONV_RAMP_MS * CLK_KHZ,
  parameter int RECOVERY_CYC    = RECOVERY_MS * CLK_KHZ,
  parameter int DISCHARGE_CYC   = DISCHARGE_MS * CLK_KHZ,
  parameter int BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * CLK_KHZ,
  parameter int SHORT_DWELL_CYC = SHORT_DWELL_MS * CLK_KHZ
) (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        ARST_N,
  // Avalon-MM register slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Pin and analog indications
  input  wire bfss_pins_s  PINS,
  // Power path and string control
  output bfss_pwr_s        PWR,
  output logic [NCH-1:0]   DRIVER_EN,
  output logic [NCH-1:0]   TEST_CURRENT,
  output logic [NCH-1:0]   ADAPT_MASK,
  output logic [11:0]      STRING_CURRENT_CODE,
  // Status
  output logic             INT,
  output logic             BUS_RESET,
  output logic [8:0]       STATE
);

  function automatic logic other_below(input logic [NCH-1:0] high, input logic [NCH-1:0] live,
                                       input int ch);
    logic [NCH-1:0] others;
    others = live & ~high;
    others[ch] = 1'b0;
    return |others;
  endfunction

  bfss_pins_s     pin;
  bfss_state_e    state_reg, state_next;
  logic           tmr_load, tmr_expired, bus_load, bus_expired;
  logic [31:0]    tmr_val;
  logic           wait_reg, wait_next;
  logic [31:0]    rdata_reg, rdata_next;
  logic [15:0]    bright_reg, bright_next;
  logic [11:0]    cur_reg, cur_next;
  logic [NFLT-1:0] flags_reg, flags_next, ien_reg, ien_next, ev;
  logic [NCH-1:0] used_reg, used_next, dis_reg, dis_next;
  logic [31:0]    short_cnt_reg [NCH];
  logic [31:0]    short_cnt_next [NCH];
  logic [NCH-1:0] open_ch, short_fire, live;
  logic           gnd_ev, all_dead, wr_acc, rd_take, cfg_ok;
  bfss_pwr_s      pwr_reg, pwr_next;
  logic [NCH-1:0] drv_reg, drv_next, test_reg, test_next, adapt_reg, adapt_next;
  logic [11:0]    code_reg, code_next;
  logic           int_reg, int_next, busrst_reg, busrst_next;

  bfss_sync #(.W($bits(bfss_pins_s))) u_sync (
    .clk     (MCLK),
    .rst_n   (ARST_N),
    .d_async (PINS),
    .q       (pin)
  );

  bfss_timer u_state_tmr (
    .clk      (MCLK),
    .rst_n    (ARST_N),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (tmr_expired)
  );

  bfss_timer u_bus_tmr (
    .clk      (MCLK),
    .rst_n    (ARST_N),
    .load     (bus_load),
    .load_val (BUS_TIMEOUT_CYC),
    .expired  (bus_expired)
  );

  // Fault detection.
  always_comb
  begin
    live    = used_reg & ~dis_reg;
    gnd_ev  = 1'b0;
    if (state_reg == ST_SOFT)
      gnd_ev = |(pin.ground_short & used_reg & test_reg);
    else if ((state_reg == ST_RAMP) || (state_reg == ST_NORMAL))
      gnd_ev = |(pin.ground_short & used_reg & ~drv_reg & test_reg);
    open_ch = '0;
    if (state_reg == ST_NORMAL && pin.target_at_max)
      open_ch = pin.headroom_low & live;
    for (int i = 0; i < NCH; i++)
    begin
      short_fire[i] = 1'b0;
      short_cnt_next[i] = 32'h0;
      if (state_reg == ST_NORMAL && live[i] && pin.headroom_high[i]
          && other_below(pin.headroom_high, live, i))
      begin
        if (short_cnt_reg[i] == SHORT_DWELL_CYC)
          short_fire[i] = 1'b1;
        else
          short_cnt_next[i] = short_cnt_reg[i] + 32'h1;
      end
    end
    ev = '0;
    ev[FLT_CURRENT_SET_PIN]    = pin.current_set_pin_short;
    ev[FLT_THERMAL] = pin.overtemp && state_reg != ST_OFF && state_reg != ST_INIT;
    ev[FLT_OPEN]    = |open_ch;
    ev[FLT_SHORT]   = |short_fire;
    ev[FLT_GROUND]  = gnd_ev;
    ev[FLT_UNUSED]  = (state_reg == ST_SOFT) && |(pin.unused_not_ground & ~used_reg);
    ev[FLT_BUS]     = pin.bus_busy && bus_expired;
    bus_load = !pin.bus_busy || bus_expired;
    dis_next = dis_reg | open_ch | short_fire;
    all_dead = (used_reg != '0) && ((used_reg & ~dis_next) == '0);
  end

  // Operating state machine.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_INIT:
        if (pin.init_done)
          state_next = pin.en ? ST_STANDBY : ST_OFF;
      ST_OFF:
        if (pin.en)
          state_next = ST_INIT;
      ST_STANDBY:
        if (!pin.en)
          state_next = ST_SHUTDOWN;
        else if (!pin.overtemp)
          state_next = ST_SOFT;
      ST_SOFT, ST_RAMP, ST_NORMAL:
        if (!pin.en)
          state_next = ST_SHUTDOWN;
        else if (pin.overtemp)
          state_next = ST_STANDBY;
        else if (gnd_ev)
          state_next = ST_RECOVERY;
        else if (all_dead && state_reg != ST_SOFT)
          state_next = ST_LATCH;
        else if (tmr_expired && state_reg == ST_SOFT)
          state_next = ST_RAMP;
        else if (tmr_expired && state_reg == ST_RAMP)
          state_next = ST_NORMAL;
      ST_RECOVERY:
        if (!pin.en)
          state_next = ST_SHUTDOWN;
        else if (tmr_expired && bright_reg != 16'h0)
          state_next = ST_STANDBY;
      ST_LATCH:
        if (!pin.en)
          state_next = ST_SHUTDOWN;
      ST_SHUTDOWN:
        if (tmr_expired)
          state_next = ST_OFF;
      default:
        state_next = ST_INIT;
    endcase
    tmr_load = (state_next != state_reg);
    case (state_next)
      ST_SOFT:     tmr_val = SOFT_START_CYC;
      ST_RAMP:     tmr_val = CONV_RAMP_CYC;
      ST_RECOVERY: tmr_val = RECOVERY_CYC;
      ST_SHUTDOWN: tmr_val = DISCHARGE_CYC;
      default:     tmr_val = 32'h1;
    endcase
  end

  // Register file and bus slave.
  always_comb
  begin
    wait_next   = !((AVS_READ || AVS_WRITE) && wait_reg);
    wr_acc      = AVS_WRITE && !wait_reg;
    rd_take     = AVS_READ && wait_reg;
    cfg_ok      = state_reg != ST_INIT && state_reg != ST_OFF && state_reg != ST_SHUTDOWN;
    bright_next = bright_reg;
    cur_next    = cur_reg;
    ien_next    = ien_reg;
    flags_next  = flags_reg;
    used_next   = used_reg;
    if (state_reg == ST_INIT && pin.init_done)
      used_next = pin.string_used;
    if (wr_acc && cfg_ok && AVS_ADDRESS == REG_BRIGHT)
      bright_next = AVS_WRITEDATA[15:0];
    if (wr_acc && cfg_ok && AVS_ADDRESS == REG_CURRENT)
      cur_next = AVS_WRITEDATA[11:0];
    for (int i = 0; i < NFLT; i++)
    begin
      if (wr_acc && AVS_ADDRESS == REG_INT_EN)
      begin
        if (AVS_WRITEDATA[2*i +: 2] == IEN_WR_OFF)
          ien_next[i] = 1'b0;
        else if (AVS_WRITEDATA[2*i +: 2] == IEN_WR_ON)
          ien_next[i] = 1'b1;
      end
      if (wr_acc && AVS_ADDRESS == REG_STATUS && AVS_WRITEDATA[i]
          && AVS_WRITEDATA[CLR_SHIFT+i])
        flags_next[i] = 1'b0;
      if (ev[i])
        flags_next[i] = 1'b1;
    end
    rdata_next = rdata_reg;
    if (rd_take)
    begin
      rdata_next = 32'h0;
      case (AVS_ADDRESS)
        REG_BRIGHT:  rdata_next[15:0] = bright_reg;
        REG_CURRENT: rdata_next[11:0] = cur_reg;
        REG_STATUS:  rdata_next[NFLT-1:0] = flags_reg;
        REG_INT_EN:
          for (int i = 0; i < NFLT; i++)
            rdata_next[2*i +: 2] = ien_reg[i] ? IEN_RD_ON : 2'h0;
        REG_STATE:   rdata_next[8:0] = state_reg;
        REG_STRINGS:
        begin
          rdata_next[NCH-1:0] = live;
          rdata_next[DIS_SHIFT +: NCH] = dis_reg;
          rdata_next[USED_SHIFT +: NCH] = used_reg;
        end
        default:     rdata_next = 32'h0;
      endcase
    end
  end

  // Registered outputs, computed from the state being entered.
  always_comb
  begin
    pwr_next = '0;
    pwr_next.init_start      = (state_next == ST_INIT);
    pwr_next.pl_switch_en    = (state_next == ST_SOFT) || (state_next == ST_RAMP)
                               || (state_next == ST_NORMAL);
    pwr_next.conv_en         = (state_next == ST_RAMP) || (state_next == ST_NORMAL);
    pwr_next.conv_ramp       = (state_next == ST_RAMP);
    pwr_next.discharge_en    = (state_next == ST_SHUTDOWN);
    pwr_next.supply_fault_en = pwr_next.pl_switch_en;
    pwr_next.conv_fault_en   = pwr_next.conv_en;
    pwr_next.led_fault_en    = (state_next == ST_NORMAL);
    adapt_next = used_next & ~dis_next;
    drv_next   = '0;
    if (state_next == ST_NORMAL && bright_next != 16'h0)
      drv_next = adapt_next;
    test_next = '0;
    if (state_next == ST_SOFT)
      test_next = used_next;
    else if (state_next == ST_RAMP || state_next == ST_NORMAL)
      test_next = adapt_next & ~drv_next;
    code_next   = pin.current_set_pin_short ? CURRENT_SET_PIN_FORCED_CODE : cur_next;
    int_next    = |(flags_next & ien_next);
    busrst_next = ev[FLT_BUS];
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_reg  <= ST_INIT;
      wait_reg   <= 1'b1;
      rdata_reg  <= 32'h0;
      bright_reg <= BRIGHT_RST;
      cur_reg    <= CURRENT_RST;
      ien_reg    <= INT_EN_RST;
      flags_reg  <= '0;
      used_reg   <= '0;
      dis_reg    <= '0;
      pwr_reg    <= '0;
      drv_reg    <= '0;
      test_reg   <= '0;
      adapt_reg  <= '0;
      code_reg   <= CURRENT_RST;
      int_reg    <= 1'b0;
      busrst_reg <= 1'b0;
      for (int i = 0; i < NCH; i++)
        short_cnt_reg[i] <= 32'h0;
    end
    else
    begin
      state_reg  <= state_next;
      wait_reg   <= wait_next;
      rdata_reg  <= rdata_next;
      bright_reg <= bright_next;
      cur_reg    <= cur_next;
      ien_reg    <= ien_next;
      flags_reg  <= flags_next;
      used_reg   <= used_next;
      dis_reg    <= dis_next;
      pwr_reg    <= pwr_next;
      drv_reg    <= drv_next;
      test_reg   <= test_next;
      adapt_reg  <= adapt_next;
      code_reg   <= code_next;
      int_reg    <= int_next;
      busrst_reg <= busrst_next;
      for (int i = 0; i < NCH; i++)
        short_cnt_reg[i] <= short_cnt_next[i];
    end
  end

  assign AVS_READDATA        = rdata_reg;
  assign AVS_WAITREQUEST     = wait_reg;
  assign PWR                 = pwr_reg;
  assign DRIVER_EN           = drv_reg;
  assign TEST_CURRENT        = test_reg;
  assign ADAPT_MASK          = adapt_reg;
  assign STRING_CURRENT_CODE = code_reg;
  assign INT                 = int_reg;
  assign BUS_RESET           = busrst_reg;
  assign STATE               = state_reg;

endmodule

// file: logic/bfss_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
module bfss_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q_reg    <= '0;
    end
    else
    begin
      meta_reg <= d_async;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule

// file: logic/bfss_timer.sv
// Loadable down counter that reports when it has run out.
module bfss_timer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        load,
  input  wire logic [31:0] load_val,
  output logic             expired
);

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;

  always_comb
  begin
    if (load)
      cnt_next = load_val;
    else if (cnt_reg != 32'h0)
      cnt_next = cnt_reg - 32'h1;
    else
      cnt_next = cnt_reg;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= 32'h0;
    else
      cnt_reg <= cnt_next;
  end

  assign expired = (cnt_reg == 32'h0);

endmodule

// file: testbench/backlight_fault_state_sequencer_tb.sv
// Self-checking bench of the backlight fault state sequencer.
module backlight_fault_state_sequencer_tb
  import bfss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [NCH-1:0] USED = 6'h1f;
  logic MCLK, ARST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, INT, BUS_RESET;
  logic [3:0]     AVS_ADDRESS;
  logic [31:0]    AVS_WRITEDATA, AVS_READDATA;
  bfss_pins_s     PINS;
  bfss_pwr_s      PWR;
  logic [NCH-1:0] DRIVER_EN, TEST_CURRENT, ADAPT_MASK, gnd, opn, shrt, misc, used;
  logic [11:0]    STRING_CURRENT_CODE, cur;
  logic [15:0]    brt;
  logic [8:0]     STATE;
  logic           en, ot, current_set_pin, busy;
  logic [69:0]    exq[$];
  logic [69:0]    ent;
  int             fails;
  int             checks;
  int             bus_rst_seen;

  bfss_sequencer #(.SOFT_START_CYC(20), .CONV_RAMP_CYC(30), .RECOVERY_CYC(40),
    .DISCHARGE_CYC(50), .BUS_TIMEOUT_CYC(60), .SHORT_DWELL_CYC(20)) uut (.MCLK(MCLK),
    .ARST_N(ARST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA), .PINS(PINS), .PWR(PWR),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .DRIVER_EN(DRIVER_EN), .TEST_CURRENT(TEST_CURRENT),
    .ADAPT_MASK(ADAPT_MASK), .STRING_CURRENT_CODE(STRING_CURRENT_CODE), .INT(INT),
    .BUS_RESET(BUS_RESET), .STATE(STATE));
  bfss_strings_model partner (.clk(MCLK), .rst_n(ARST_N), .used(used), .en(en), .ot(ot),
    .current_set_pin(current_set_pin), .busy(busy), .gnd(gnd), .opn(opn), .shrt(shrt), .misc(misc),
    .adapt(ADAPT_MASK), .pins(PINS));

  initial
  begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end

  task automatic finish_test();
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One Avalon transfer; a read files its expected value for the monitor.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [1:0] ic, output logic [31:0] q);
    int n;
    n = 0;
    AVS_ADDRESS   <= a;
    AVS_WRITEDATA <= wr ? d : 32'h0;
    AVS_WRITE     <= wr;
    AVS_READ      <= !wr;
    if (!wr)
      exq.push_back({a, d, m, ic});
    @(posedge MCLK);
    while (AVS_WAITREQUEST !== 1'b0)
    begin
      n++;
      if (n > 20)
      begin
        fails++;
        finish_test();
      end
      @(posedge MCLK);
    end
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ  <= 1'b0;
    @(posedge MCLK);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 32'h0, 2'b00, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffffffff, input logic [1:0] ic = 2'b00);
    logic [31:0] q;
    bus(1'b0, a, e, m, ic, q);
  endtask

  task automatic wait_st(input logic [8:0] s);
    logic [31:0] q;
    int n;
    q = 32'h0;
    n = 0;
    while (q[8:0] !== s)
    begin
      n++;
      if (n > 3000)
      begin
        fails++;
        finish_test();
      end
      bus(1'b0, REG_STATE, 32'h0, 32'h0, 2'b00, q);
    end
  endtask

  always @(posedge MCLK)
  begin
    if (BUS_RESET === 1'b1)
      bus_rst_seen++;
    if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0 && exq.size() > 0)
    begin
      ent = exq.pop_front();
      checks++;
      if ((AVS_READDATA & ent[33:2]) !== ent[65:34])
      begin
        fails++;
        $display("MISMATCH reg %0h exp %h got %h", ent[69:66], ent[65:34], AVS_READDATA);
      end
      if (ent[1] && INT !== ent[0])
      begin
        fails++;
        $display("MISMATCH INT exp %b got %b", ent[0], INT);
      end
    end
  end

  initial
  begin
    {ARST_N, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA} = '0;
    {ot, current_set_pin, busy, gnd, opn, shrt, misc} = '0;
    en = 1'b1;
    used = USED;
    bus_rst_seen = 0;
    fails = 0;
    checks = 0;
    void'($urandom(32'h3a3f));
    cur = 12'($urandom());
    brt = 16'($urandom()) | 16'h1;
    repeat (4) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    rd(REG_BRIGHT, {16'h0, BRIGHT_RST});
    rd(REG_CURRENT, {20'h0, CURRENT_RST});
    rd(REG_INT_EN, 32'h2aaa);
    rd(4'h9, 32'h0);
    wait_st(ST_NORMAL);
    rd(REG_STRINGS, {10'h0, USED, 10'h0, USED});
    wr(REG_CURRENT, {20'h0, cur});
    rd(REG_CURRENT, {20'h0, cur});
    wr(REG_BRIGHT, {16'h0, brt});
    rd(REG_BRIGHT, {16'h0, brt});
    current_set_pin <= 1'b1;
    repeat (6) @(posedge MCLK);
    rd(REG_STATUS, 32'h1, 32'h7f, 2'b11);
    rd(REG_STATE, {23'h0, ST_NORMAL});
    wr(REG_STATUS, 32'h1);
    current_set_pin <= 1'b0;
    repeat (6) @(posedge MCLK);
    rd(REG_STATUS, 32'h1, 32'h7f);
    wr(REG_STATUS, 32'h10001);
    rd(REG_STATUS, 32'h0, 32'h7f, 2'b10);
    wr(REG_INT_EN, 32'h1);
    rd(REG_INT_EN, 32'h2aa8);
    current_set_pin <= 1'b1;
    repeat (6) @(posedge MCLK);
    rd(REG_STATUS, 32'h1, 32'h7f, 2'b10);
    wr(REG_INT_EN, 32'h3);
    rd(REG_INT_EN, 32'h2aaa, 32'hffffffff, 2'b11);
    current_set_pin <= 1'b0;
    repeat (6) @(posedge MCLK);
    wr(REG_STATUS, 32'h10001);
    wr(REG_BRIGHT, 32'h0);
    gnd <= 6'h01;
    wait_st(ST_RECOVERY);
    rd(REG_STATUS, 32'h10, 32'h7f);
    gnd  <= 6'h00;
    misc <= 6'h20;
    repeat (60) @(posedge MCLK);
    rd(REG_STATE, {23'h0, ST_RECOVERY});
    wr(REG_BRIGHT, {16'h0, brt});
    wait_st(ST_NORMAL);
    rd(REG_STATUS, 32'h30, 32'h7f);
    wr(REG_STATUS, 32'h300030);
    misc <= 6'h00;
    busy <= 1'b1;
    repeat (70) @(posedge MCLK);
    busy <= 1'b0;
    rd(REG_STATUS, 32'h40, 32'h7f);
    checks++;
    if (bus_rst_seen !== 1)
    begin
      fails++;
      $display("MISMATCH BUS_RESET pulses exp 1 got %0d", bus_rst_seen);
    end
    rd(REG_STATE, {23'h0, ST_NORMAL});
    opn <= 6'h02;
    repeat (8) @(posedge MCLK);
    rd(REG_STRINGS, 32'h1f021d);
    rd(REG_STATUS, 32'h4, 32'h4);
    shrt <= 6'h04;
    repeat (30) @(posedge MCLK);
    rd(REG_STRINGS, 32'h1f0619);
    rd(REG_STATUS, 32'h8, 32'h8);
    ot <= 1'b1;
    repeat (6) @(posedge MCLK);
    rd(REG_STATE, {23'h0, ST_STANDBY});
    repeat (20) @(posedge MCLK);
    rd(REG_STATUS, 32'h2, 32'h2);
    rd(REG_STATE, {23'h0, ST_STANDBY});
    ot <= 1'b0;
    wait_st(ST_NORMAL);
    opn <= 6'h1b;
    wait_st(ST_LATCH);
    opn <= 6'h00;
    repeat (20) @(posedge MCLK);
    rd(REG_STATE, {23'h0, ST_LATCH});
    en <= 1'b0;
    wait_st(ST_SHUTDOWN);
    wait_st(ST_OFF);
    // A second power cycle with another string pattern re-enables every disabled string.
    used   <= 6'h3e;
    shrt   <= 6'h00;
    en     <= 1'b1;
    ARST_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    wait_st(ST_NORMAL);
    rd(REG_STRINGS, 32'h3e003e);
    finish_test();
  end
endmodule

bind bfss_sequencer bfss_asserts #(.SOFT_START_CYC(SOFT_START_CYC),
  .CONV_RAMP_CYC(CONV_RAMP_CYC), .RECOVERY_CYC(RECOVERY_CYC), .DISCHARGE_CYC(DISCHARGE_CYC))
  u_chk (.MCLK(MCLK), .ARST_N(ARST_N), .PINS(PINS), .PWR(PWR), .DRIVER_EN(DRIVER_EN),
  .STRING_CURRENT_CODE(STRING_CURRENT_CODE), .STATE(STATE));

// file: testbench/bfss_asserts.sv
// Concurrent checks on the state sequencing and power outputs of the sequencer.
module bfss_asserts
  import bfss_pkg::*;
#(
  parameter int SOFT_START_CYC = 20,
  parameter int CONV_RAMP_CYC  = 30,
  parameter int RECOVERY_CYC   = 40,
  parameter int DISCHARGE_CYC  = 50
) (
  // Clock and reset
  input wire logic           MCLK,
  input wire logic           ARST_N,
  // Observed ports
  input wire bfss_pins_s     PINS,
  input wire bfss_pwr_s      PWR,
  input wire logic [NCH-1:0] DRIVER_EN,
  input wire logic [11:0]    STRING_CURRENT_CODE,
  input wire logic [8:0]     STATE
);
  logic [8:0]  st_reg;
  logic [8:0]  st_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!ARST_N);

  // Counts the samples for which the present state has been held.
  always_comb
  begin
    st_next  = STATE;
    cnt_next = (STATE == st_reg) ? cnt_reg + 32'h1 : 32'h1;
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      st_reg  <= 9'h001;
      cnt_reg <= 32'h0;
    end
    else
    begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
    end
  end

  property p_current_set_pin;
    PINS.current_set_pin_short [*4] |-> STRING_CURRENT_CODE == CURRENT_SET_PIN_FORCED_CODE;
  endproperty
  a_current_set_pin: assert property (p_current_set_pin) else $error("current code not forced");
  property p_standby;
    (STATE == ST_STANDBY && PINS.en && !PINS.overtemp) [*3] |=> STATE == ST_SOFT;
  endproperty
  a_standby: assert property (p_standby) else $error("standby held");
  property p_soft_len;
    STATE == ST_RAMP && st_reg == ST_SOFT |-> cnt_reg == 32'(SOFT_START_CYC + 1);
  endproperty
  a_soft_len: assert property (p_soft_len) else $error("soft start length");
  property p_ramp_len;
    STATE == ST_NORMAL && st_reg == ST_RAMP |-> cnt_reg == 32'(CONV_RAMP_CYC + 1);
  endproperty
  a_ramp_len: assert property (p_ramp_len) else $error("ramp length");
  property p_soft_pwr;
    STATE == ST_SOFT && st_reg == ST_SOFT |-> PWR.pl_switch_en && PWR.supply_fault_en
      && !PWR.conv_en;
  endproperty
  a_soft_pwr: assert property (p_soft_pwr) else $error("soft start outputs");
  property p_rec_len;
    STATE == ST_STANDBY && st_reg == ST_RECOVERY |-> cnt_reg > 32'(RECOVERY_CYC);
  endproperty
  a_rec_len: assert property (p_rec_len) else $error("recovery too short");
  property p_rec_off;
    STATE == ST_RECOVERY && st_reg == ST_RECOVERY |-> !PWR.pl_switch_en && !PWR.conv_en
      && DRIVER_EN == '0;
  endproperty
  a_rec_off: assert property (p_rec_off) else $error("power on in recovery");
  property p_shut_len;
    STATE == ST_OFF && st_reg == ST_SHUTDOWN |-> cnt_reg == 32'(DISCHARGE_CYC + 1);
  endproperty
  a_shut_len: assert property (p_shut_len) else $error("discharge length");
  property p_shut_off;
    STATE == ST_SHUTDOWN && st_reg == ST_SHUTDOWN |-> PWR.discharge_en && !PWR.conv_en
      && !PWR.pl_switch_en && DRIVER_EN == '0;
  endproperty
  a_shut_off: assert property (p_shut_off) else $error("shutdown outputs");
  property p_en_low;
    (!PINS.en && STATE != ST_INIT && STATE != ST_OFF && STATE != ST_SHUTDOWN) [*3]
      |=> STATE == ST_SHUTDOWN;
  endproperty
  a_en_low: assert property (p_en_low) else $error("enable low ignored");
  property p_latch;
    STATE == ST_LATCH |=> STATE == ST_LATCH || STATE == ST_SHUTDOWN;
  endproperty
  a_latch: assert property (p_latch) else $error("latch left");
endmodule

// file: testbench/bfss_strings_model.sv
// Behavioural model of the control pins and LED strings around the sequencer.
module bfss_strings_model
  import bfss_pkg::*;
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // Scenario knobs
  input  wire logic [NCH-1:0] used,
  input  wire logic           en,
  input  wire logic           ot,
  input  wire logic           current_set_pin,
  input  wire logic           busy,
  input  wire logic [NCH-1:0] gnd,
  input  wire logic [NCH-1:0] opn,
  input  wire logic [NCH-1:0] shrt,
  input  wire logic [NCH-1:0] misc,
  input  wire logic [NCH-1:0] adapt,
  // Pins seen by the device
  output bfss_pins_s          pins
);
  logic [3:0] init_cnt;

  // Regulator and resistor detection settle a few cycles after reset.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      init_cnt <= 4'h0;
    else if (init_cnt != 4'hf)
      init_cnt <= init_cnt + 4'h1;
  end

  // The ground-short level follows gnd directly, whether or not the output sinks current.
  always_comb
  begin
    pins                   = '0;
    pins.en                = en;
    pins.overtemp          = ot;
    pins.current_set_pin_short        = current_set_pin;
    pins.init_done         = init_cnt == 4'hf;
    pins.bus_busy          = busy;
    pins.string_used       = used;
    pins.target_at_max     = (opn & adapt) != '0;
    pins.headroom_low      = opn;
    pins.headroom_high     = shrt;
    pins.ground_short      = gnd;
    pins.unused_not_ground = misc & ~used;
  end
endmodule
